// file: src/aascp_pkg.sv
/*
  Constants and carriers for the amplifier-array serial configuration port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package aascp_pkg;

  // ------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------
  localparam int FRAME_BITS  = 40;
  localparam int BYTE_BITS   = 8;
  localparam int DATA_BYTES  = 4;
  localparam int CHANNELS    = 8;
  localparam int ROUTE_BITS  = 4;
  localparam int CNT_W       = 6;
  localparam logic [5:0] LAST_BIT = 6'h27;

  // ------------------------------------------------------------
  // Control byte fields
  // ------------------------------------------------------------
  localparam int CTL_START   = 0;
  localparam int CTL_WRITE   = 1;
  localparam int CTL_PWROFF  = 2;
  localparam int CTL_ATTEN   = 3;
  localparam int CTL_PATH    = 5;
  localparam int CTL_GAIN    = 6;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [31:0] ROUTE_RESET = 32'hFFFFFFFF;
  localparam logic [3:0]  ROUTE_LAST_OUT = 4'h9;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    AASCP_IDLE  = 2'b00,
    AASCP_SHIFT = 2'b01
  } aascp_state_e;

  typedef struct packed {
    logic       chipPowerOff;
    logic [1:0] attenRange;
    logic       timeGainPath;
    logic [1:0] gainStep;
  } aascp_ctl_s;

  typedef struct packed {
    logic       timeGainOn;
    logic       dopplerOn;
    logic       chipOn;
  } aascp_pwr_s;

endpackage

// file: src/aascp_route_decode.sv
/*
  Decoder of one channel's routing code into output-select lines.
  Assumes a stable latched code from the configuration registers.
*/
`timescale 1ns/1ps
module aascp_route_decode
(
  input  wire logic [3:0] code,    // Routing code of one channel
  output logic [9:0]      outSel,  // One-hot continuous-wave output select
  output logic            tiedHigh // Channel tied to internal supply
);

  always_comb
  begin
    outSel   = 10'h000;
    tiedHigh = 1'b1;
    if (code <= aascp_pkg::ROUTE_LAST_OUT)
    begin
      outSel[code] = 1'b1;
      tiedHigh     = 1'b0;
    end
  end

endmodule

// file: src/aascp_top.sv
/*
  Serial configuration port of an eight-channel receive amplifier array.
  Assumes a host driving select, serial clock and serial input; the link
  logic runs on the serial clock, outputs other than serialOut are resynchronised to clk.
*/
// What this block does
// - Frame counts forty bits from first one
// - Bit one: write latches routing, read not
// - Bit two set powers whole chip off
// - Bit five picks time-gain or doppler path
// - Bits six-seven give the gain field
// - Gain codes step upward in order
// - Control byte first, then four data bytes
// - Lower channel in low nibble
// - Codes to nine route, others tie high
// - Every transfer has the same length
// - Separate input and output data lines
// - Output stream mirrors input bit order
// - Read-back comes from the shift register
// - Output always shows shifted data
// - Permanent select framed by start bits
`timescale 1ns/1ps
module aascp_top
(
  input  wire logic        clk,          // System clock, 40 MHz
  input  wire logic        resetn,       // Asynchronous reset, active low
  input  wire logic        serialClk,    // Serial clock from host
  input  wire logic        selectN,      // Chip select, active low
  input  wire logic        serialIn,     // Serial data input
  output logic             serialOut,    // Serial data output
  output aascp_pkg::aascp_ctl_s ctl,     // Latched control fields
  output aascp_pkg::aascp_pwr_s chip_power_off,     // Power enables
  output logic [31:0]      route,        // Latched routing codes, channel 1 low
  output logic [79:0]      outSel,       // Ten selects per channel
  output logic [7:0]       tiedHigh,     // Channel tied to supply
  output logic             readBack,     // Last frame was a read
  output logic             frameDone     // One-cycle pulse per latched frame
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rstMeta;
  logic rstSync;
  logic lnkRstA;
  logic lnkRstB;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ------------------------------------------------------------
  // Link-side reset release
  // ------------------------------------------------------------
  always_ff @(posedge serialClk or negedge resetn)
  begin
    if (!resetn)
    begin
      lnkRstA <= 1'b0;
      lnkRstB <= 1'b0;
    end
    else
    begin
      lnkRstA <= 1'b1;
      lnkRstB <= lnkRstA;
    end
  end

  // ------------------------------------------------------------
  // Link side: framing and shifting
  // ------------------------------------------------------------
  aascp_pkg::aascp_state_e state;
  aascp_pkg::aascp_state_e next_state;
  logic [5:0]  bitCnt;
  logic [5:0]  next_bitCnt;
  logic [39:0] shiftReg;
  logic [39:0] next_shift;
  logic [39:0] frameWord;
  logic        frameTgl;
  logic        abort;
  logic        lastBit;
  logic        frameEnd;

  // Select high clears the frame at once, no serial edge needed
  assign abort      = selectN;
  assign lastBit    = (bitCnt == aascp_pkg::LAST_BIT);
  assign frameEnd   = !selectN && (state == aascp_pkg::AASCP_SHIFT) && lastBit;
  assign next_shift = {serialIn, shiftReg[39:1]};

  // Leading zeros wait in idle; the first one opens a frame
  always_comb
  begin
    next_state  = state;
    next_bitCnt = bitCnt;
    case (state)
      aascp_pkg::AASCP_IDLE:
      begin
        if (serialIn)
        begin
          next_state  = aascp_pkg::AASCP_SHIFT;
          next_bitCnt = 6'h01;
        end
      end
      aascp_pkg::AASCP_SHIFT:
      begin
        if (lastBit)
        begin
          next_state  = aascp_pkg::AASCP_IDLE;
          next_bitCnt = 6'h00;
        end
        else
        begin
          next_bitCnt = bitCnt + 6'h01;
        end
      end
      default:
      begin
        next_state  = aascp_pkg::AASCP_IDLE;
        next_bitCnt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge serialClk or posedge abort)
  begin
    if (abort)
    begin
      state  <= aascp_pkg::AASCP_IDLE;
      bitCnt <= 6'h00;
    end
    else if (!lnkRstB)
    begin
      state  <= aascp_pkg::AASCP_IDLE;
      bitCnt <= 6'h00;
    end
    else
    begin
      state  <= next_state;
      bitCnt <= next_bitCnt;
    end
  end

  // ------------------------------------------------------------
  // Link side: shift register and output stream
  // ------------------------------------------------------------
  // Shift register: first bit lands at bit 0 once the frame is full
  always_ff @(posedge serialClk or negedge lnkRstB)
  begin
    if (!lnkRstB)
      shiftReg <= 40'h0000000000;
    else if (!selectN)
      shiftReg <= next_shift;
  end

  // Output stream replays the shift register in arrival order
  always_ff @(negedge serialClk or negedge lnkRstB)
  begin
    if (!lnkRstB)
      serialOut <= 1'b0;
    else
      serialOut <= shiftReg[0];
  end

  // ------------------------------------------------------------
  // Link side: frame capture
  // ------------------------------------------------------------
  // Whole frame held until the next one completes
  always_ff @(posedge serialClk or negedge lnkRstB)
  begin
    if (!lnkRstB)
      frameWord <= 40'h0000000000;
    else if (frameEnd)
      frameWord <= next_shift;
  end

  // One toggle per completed frame, carried into clk
  always_ff @(posedge serialClk or negedge lnkRstB)
  begin
    if (!lnkRstB)
      frameTgl <= 1'b0;
    else if (frameEnd)
      frameTgl <= ~frameTgl;
  end

  // ------------------------------------------------------------
  // Crossing into clk
  // ------------------------------------------------------------
  logic tglMeta;
  logic tglSync;
  logic tglSeen;
  logic newFrame;

  // Toggle passes two flops, the third one detects its edge
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      tglMeta <= 1'b0;
      tglSync <= 1'b0;
      tglSeen <= 1'b0;
    end
    else
    begin
      tglMeta <= frameTgl;
      tglSync <= tglMeta;
      tglSeen <= tglSync;
    end
  end

  assign newFrame = tglSync ^ tglSeen;

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0]  ctlByte;
  logic [31:0] next_route;

  // frameWord is stable for many clk cycles after the toggle is seen
  assign next_route = frameWord[39:8];

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      frameDone <= 1'b0;
    else
      frameDone <= newFrame;
  end

  // Control byte is taken on reads and writes alike
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      ctlByte <= aascp_pkg::CTL_RESET;
    else if (newFrame)
      ctlByte <= frameWord[7:0];
  end

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      readBack <= 1'b0;
    else if (newFrame)
      readBack <= ~frameWord[aascp_pkg::CTL_WRITE];
  end

  // Routing only moves on a write frame
  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
      route <= aascp_pkg::ROUTE_RESET;
    else if (newFrame && frameWord[aascp_pkg::CTL_WRITE])
      route <= next_route;
  end

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  always_comb
  begin
    ctl.chipPowerOff = ctlByte[aascp_pkg::CTL_PWROFF];
    ctl.attenRange   = ctlByte[aascp_pkg::CTL_ATTEN +: 2];
    ctl.timeGainPath = ctlByte[aascp_pkg::CTL_PATH];
    ctl.gainStep     = ctlByte[aascp_pkg::CTL_GAIN +: 2];
  end

  // ------------------------------------------------------------
  // Power enables
  // ------------------------------------------------------------
  // Power-off wins over both paths
  always_comb
  begin
    chip_power_off.chipOn       = ~ctlByte[aascp_pkg::CTL_PWROFF];
    chip_power_off.timeGainOn   = chip_power_off.chipOn & ctlByte[aascp_pkg::CTL_PATH];
    chip_power_off.dopplerOn    = chip_power_off.chipOn & ~ctlByte[aascp_pkg::CTL_PATH];
  end

  // ------------------------------------------------------------
  // Switch matrix decode, one per channel
  // ------------------------------------------------------------
  for (genvar ch = 0; ch < aascp_pkg::CHANNELS; ch++)
  begin : gRoute
    aascp_route_decode uDec
    (
      .code     (route[ch*4 +: 4]),
      .outSel   (outSel[ch*10 +: 10]),
      .tiedHigh (tiedHigh[ch])
    );
  end

endmodule

// file: testbench/aascp_assertions.sv
/* Checker of the port outputs.
   Assumes a bind onto aascp_top. */
`timescale 1ns/1ps
module aascp_assertions
(
  input wire logic                  clk,       // Clock
  input wire logic                  resetn,    // Reset
  input wire aascp_pkg::aascp_ctl_s ctl,       // Control
  input wire aascp_pkg::aascp_pwr_s chip_power_off,       // Power
  input wire logic [31:0]           route,     // Routing
  input wire logic [79:0]           outSel,    // Selects
  input wire logic [7:0]            tiedHigh,  // Tied
  input wire logic                  readBack,  // Read
  input wire logic                  frameDone  // Done
);
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_chip_power: assert property (chip_power_off.chipOn == !ctl.chipPowerOff)
    else $error("chip power wrong");
  a_path_select: assert property (!ctl.chipPowerOff |->
    chip_power_off.timeGainOn == ctl.timeGainPath && chip_power_off.dopplerOn == !ctl.timeGainPath)
    else $error("path power wrong");
  a_tie_decode: assert property (tiedHigh[7] == (route[31:28] > 4'h9))
    else $error("tie decode wrong");
  a_sel_decode: assert property (route[3:0] <= 4'h9 |->
    outSel[9:0] == (10'h001 << route[3:0]))
    else $error("select decode wrong");
  a_ctl_hold: assert property ($changed(ctl) |-> frameDone)
    else $error("control moved");
  a_route_hold: assert property ($changed(route) |-> frameDone && !readBack)
    else $error("routing moved");
  a_done_pulse: assert property (frameDone |=> !frameDone)
    else $error("done too long");
  a_read_hold: assert property ($changed(readBack) |-> frameDone)
    else $error("read flag moved");
  c_write: cover property (frameDone && !readBack);
  c_read: cover property (frameDone && readBack);
  c_off: cover property (frameDone && ctl.chipPowerOff);
endmodule

// file: testbench/aascp_host_model.sv
/* Host model driving the serial link.
   Assumes sampling on rising serialClk. */
`timescale 1ns/1ps
module aascp_host_model
(
  output logic serialClk, // Serial clock
  output logic selectN,   // Select
  output logic serialIn,  // Data
  input  logic serialOut  // Data back from the device
);
  logic [39:0] echo;
  initial
  begin
    serialClk = 1'b0;
    selectN = 1'b1;
    serialIn = 1'b1;
    echo = 40'h0;
  end
  // ----------------
  // Bit and frame
  // ----------------
  task automatic sbit(input logic b);
    serialIn = b;
    #32 echo = {serialOut, echo[39:1]};
    serialClk = 1'b1;
    #32 serialClk = 1'b0;
  endtask
  task automatic xfer(input logic [39:0] w, input int n, input bit rel);
    selectN = 1'b0;
    repeat (3) sbit(1'b0);
    for (int i = 0; i < n; i++)
      sbit(w[i]);
    selectN = rel;
    serialIn = ~serialIn;
  endtask
endmodule

// file: testbench/aascp_top_tb.sv
/* Self-checking bench of the serial configuration port.
   Assumes the host model and the checker. */
`timescale 1ns/1ps
module aascp_top_tb;
  logic                  clk, resetn, serialClk, selectN, serialIn;
  logic                  serialOut, readBack, frameDone;
  aascp_pkg::aascp_ctl_s ctl;
  aascp_pkg::aascp_pwr_s chip_power_off;
  logic [31:0]           route, expRoute, r;
  logic [79:0]           outSel;
  logic [7:0]            tiedHigh, c;
  logic [39:0]           prevW;
  integer                seed = 32'hc76f, n_mismatch = 0, n_tests = 0, nDone = 0, n;
  aascp_top u_dut (.clk(clk), .resetn(resetn), .serialClk(serialClk),
    .selectN(selectN), .serialIn(serialIn), .serialOut(serialOut), .ctl(ctl),
    .chip_power_off(chip_power_off), .route(route), .outSel(outSel), .tiedHigh(tiedHigh),
    .readBack(readBack), .frameDone(frameDone));
  aascp_host_model u_host (.serialClk(serialClk), .selectN(selectN),
    .serialIn(serialIn), .serialOut(serialOut));
  always #12.5 clk = ~clk;
  always @(posedge clk)
    if (frameDone === 1'b1)
      nDone <= nDone + 1;
  // ----------------
  // Helpers
  // ----------------
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [5:0] expCtl(input logic [7:0] b);
    return {b[2], b[4:3], b[5], b[7:6]};
  endfunction
  function automatic logic [9:0] expSel(input logic [3:0] code);
    return (code > 4'h9) ? 10'h000 : (10'h001 << code);
  endfunction
  // ----------------
  // Tests
  // ----------------
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    expRoute = 32'hFFFFFFFF;
    prevW = 40'h0;
    fork
      #1 u_host.xfer(40'h0, 0, 1'b0);
      repeat (16) @(posedge clk);
    join
    #2 resetn = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      c = 8'($random(seed));
      r = $random(seed);
      c[0] = 1'b1;
      c[7:6] = i[1:0];
      if (i < 2)
        c[1] = i[0];
      n = nDone;
      u_host.xfer({r, c}, (i == 9) ? 20 : 40, i[0]);
      if (i == 9)
        cmp(u_host.echo[39:20], prevW[22:3]);
      else if (i > 0)
        cmp(u_host.echo, {3'b000, prevW[39:3]});
      prevW = {r, c};
      repeat (10) @(posedge clk);
      #2;
      if (i < 9)
      begin
        if (c[1])
          expRoute = r;
        cmp(nDone - n, 1);
        cmp(ctl, expCtl(c));
        cmp(readBack, !c[1]);
        cmp(chip_power_off, {~c[2] & c[5], ~c[2] & ~c[5], ~c[2]});
      end
      else
        cmp(nDone - n, 0);
      cmp(route, expRoute);
      for (int k = 0; k < 8; k++)
      begin
        cmp(tiedHigh[k], expRoute[4*k+:4] > 4'h9);
        cmp(outSel[10*k+:10], expSel(expRoute[4*k+:4]));
      end
      $display("test %0d done", i);
    end
    stop_test();
  end
  initial
  begin
    #400000;
    n_mismatch++;
    stop_test();
  end
endmodule
bind aascp_top aascp_assertions u_chk (.clk(clk), .resetn(resetn), .ctl(ctl),
  .chip_power_off(chip_power_off), .route(route), .outSel(outSel), .tiedHigh(tiedHigh),
  .readBack(readBack), .frameDone(frameDone));
